// File: shared/adc_pins_defines.svh
// Named constants for the dual converter digital pin interface
`ifndef ADC_PINS_DEFINES_SVH
`define ADC_PINS_DEFINES_SVH

// Serial frame: 1 direction bit, 7 address bits, 24 data bits, MSB first
`define SP_CMD_LAST     5'h07
`define SP_FRAME_LAST   5'h1F
`define SP_CNT_W        5
`define SP_DATA_W       24
`define SP_FRAME_W      32
`define SP_ADDR_W       7

// Register addresses
`define REG_CFG         7'h00
`define REG_STAT        7'h01

// Configuration register reset value and bit positions
`define CFG_DEFAULT     24'h000000
`define CFG_PWR_DOWN    0
`define CFG_A_FALL_MID  1
`define CFG_B_FALL_MID  2
`define CFG_B_ON_A_CLK  3
`define CFG_SYNC_DIS    4
`define CFG_OVRA_SYNC   5
`define CFG_OVRB_SYNC   6
`define CFG_FOUR_WIRE   16

// Data path
`define SAMPLE_W        12
`define FIFO_W          26
`define FIFO_DEPTH      16
`define FIFO_LVL_W      5
`define WORD_OVR_A      24
`define WORD_OVR_B      25
`define STAT_PAD_W      17

// Output timing: four system cycles per forwarded clock period
`define PH_W            2
`define PH_START        2'h0
`define SYNC_CNT_W      4
`define SYNC_MARK       4'h0

`endif

// File: shared/adc_pins_pkg.sv
// Types shared by the converter digital pin interface
package adc_pins_pkg;

  // Serial port frame sequencer
  typedef enum logic [1:0] {
    SP_IDLE  = 2'b00,  // Waiting for a select falling edge
    SP_CMD   = 2'b01,  // Shifting in direction and address
    SP_WRITE = 2'b10,  // Shifting in write data
    SP_READ  = 2'b11   // Shifting out read data
  } serial_state_e;

endpackage

// File: logic/sample_fifo.sv
// Sample buffer between converter core and output buses
`timescale 1ns/10ps
`default_nettype none
`include "adc_pins_defines.svh"

module sample_fifo #(
  parameter int WIDTH = `FIFO_W,     // Word width
  parameter int DEPTH = `FIFO_DEPTH  // Word count, power of two
) (
  input  wire logic             clk_sys,    // System clock
  input  wire logic             rst,        // Synchronous reset, active high
  input  wire logic             clear,      // Flush all words
  input  wire logic             in_valid,   // Write request
  output logic                  in_ready,   // Room for one word
  input  wire logic [WIDTH-1:0] in_data,    // Write word
  output logic                  out_valid,  // A word is available
  input  wire logic             out_ready,  // Drain takes the word
  output logic [WIDTH-1:0]      out_data,   // Oldest word
  output logic [$clog2(DEPTH):0] level      // Words held
);

  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW + 1;
  localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];   // Storage array
  logic [AW-1:0]    wr_ptr_ff;        // Next write slot
  logic [AW-1:0]    rd_ptr_ff;        // Oldest slot
  logic [LW-1:0]    level_ff;         // Occupancy
  logic             in_ready_ff;      // Registered not-full
  logic             out_valid_ff;     // Registered not-empty

  wire logic          push = in_valid && in_ready_ff && !clear;   // Accepted write
  wire logic          pop  = out_ready && out_valid_ff && !clear; // Accepted read
  wire logic [LW-1:0] nxt_level = clear ? '0 : (level_ff + LW'(push) - LW'(pop));

  // Storage carries no reset; only the pointers, level and flags are control state
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and flags; flags come from the next level so ready is honest
  always_ff @(posedge clk_sys) begin
    if (rst || clear) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      level_ff     <= '0;
      in_ready_ff  <= 1'b0;
      out_valid_ff <= 1'b0;
    end else begin
      wr_ptr_ff    <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
      rd_ptr_ff    <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
      level_ff     <= nxt_level;
      in_ready_ff  <= (nxt_level != FULL_LVL);
      out_valid_ff <= (nxt_level != '0);
    end
  end

  assign in_ready  = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data  = mem_ff[rd_ptr_ff];
  assign level     = level_ff;

endmodule
`default_nettype wire

// File: logic/adc_pin_interface.sv
// Serial control port and DDR sample output stage of a dual converter
//
// What this block does
// - Serial reset low clears configuration, asynchronously.
// - Chip enable high; register bit also powers down.
// - Data pin two-way, input only in four-wire.
// - Separate data output driven only in four-wire.
// - Each channel drives 12-bit sample, MSB bit 11.
// - Own forwarded clock; rising or falling edge centered.
// - Option: channel B timed by channel A clock.
// - Sync output for alignment, disable bit available.
// - Overrange high above full scale, or sync.
// - Sync input rising edge restarts dividers, logic, sync out.
`timescale 1ns/10ps
`default_nettype none
`include "adc_pins_defines.svh"

module adc_pin_interface (
  input  wire logic                 clk_sys,             // System clock, 20 MHz
  input  wire logic                 rst,                 // Synchronous reset, active high
  input  wire logic                 serial_port_reset_n, // Register reset pin, active low
  input  wire logic                 chip_enable,         // Chip enable pin, active high
  input  wire logic                 serial_clock,        // Serial clock pin
  input  wire logic                 serial_select_n,     // Serial select pin, active low
  input  wire logic                 serial_dio_in,       // Two-way data pin, input side
  output logic                      serial_dio_out,      // Two-way data pin, output side
  output logic                      serial_dio_oe,       // Two-way data pin, drive enable
  output logic                      serial_data_out,     // Separate data output pin
  output logic                      serial_data_out_oe,  // Separate output drive enable
  input  wire logic                 sync_in_pair,        // Sync input pin
  input  wire logic [`SAMPLE_W-1:0] core_sample_a,       // Channel A sample from core
  input  wire logic [`SAMPLE_W-1:0] core_sample_b,       // Channel B sample from core
  input  wire logic                 core_over_a,         // Channel A above full scale
  input  wire logic                 core_over_b,         // Channel B above full scale
  input  wire logic                 core_valid,          // Core offers a sample pair
  output logic                      core_ready,          // Buffer accepts a sample pair
  output logic [`SAMPLE_W-1:0]      chan_a_sample_bus,   // Channel A output bus
  output logic [`SAMPLE_W-1:0]      chan_b_sample_bus,   // Channel B output bus
  output logic                      chan_a_fwd_clock,    // Channel A forwarded clock
  output logic                      chan_b_fwd_clock,    // Channel B forwarded clock
  output logic                      sync_out_pair,       // Sync output
  output logic                      chan_a_overrange,    // Channel A overrange output
  output logic                      chan_b_overrange,    // Channel B overrange output
  output logic                      core_sync_reset,     // Pulse restarting core dividers
  output logic                      powered_down         // Block is powered down
);

  // Pin synchronisers: stage one is read only by stage two
  logic [4:0] pin_s1_ff;   // First stage
  logic [4:0] pin_s2_ff;   // Second stage
  logic [4:0] pin_s3_ff;   // Delayed copy for edge detection

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1_ff <= 5'h02;
      pin_s2_ff <= 5'h02;
      pin_s3_ff <= 5'h02;
    end else begin
      pin_s1_ff <= {sync_in_pair, chip_enable, serial_dio_in, serial_select_n, serial_clock};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  wire logic sclk_rise = pin_s2_ff[0] && !pin_s3_ff[0];   // Host clock rose
  wire logic sel_n     = pin_s2_ff[1];                    // Select, active low
  wire logic sel_fall  = !pin_s2_ff[1] && pin_s3_ff[1];   // Frame opens
  wire logic din       = pin_s2_ff[2];                    // Serial input bit
  wire logic enable_s  = pin_s3_ff[3];                    // Chip enable level
  wire logic sync_rise = pin_s2_ff[4] && !pin_s3_ff[4];   // Sync seen high after low

  // Serial frame state
  adc_pins_pkg::serial_state_e state_ff;       // Sequencer state
  adc_pins_pkg::serial_state_e nxt_state;      // Next sequencer state
  logic [`SP_CNT_W-1:0]        bit_cnt_ff;     // Host clock rises in frame
  logic [`SP_FRAME_W-1:0]      in_shift_ff;    // Incoming bits
  logic [`SP_DATA_W-1:0]       rd_shift_ff;    // Outgoing read data
  logic [`SP_ADDR_W-1:0]       addr_ff;        // Addressed register
  logic [`SP_DATA_W-1:0]       cfg_ff;         // Configuration register

  wire logic                  last_cmd_bit = sclk_rise && (bit_cnt_ff == `SP_CMD_LAST);
  wire logic                  last_bit     = sclk_rise && (bit_cnt_ff == `SP_FRAME_LAST);
  wire logic [`SP_ADDR_W-1:0] cmd_addr     = {in_shift_ff[5:0], din};
  wire logic                  cmd_read     = in_shift_ff[6];
  wire logic [`SP_DATA_W-1:0] wr_word      = {in_shift_ff[`SP_DATA_W-2:0], din};
  wire logic                  cfg_write    = (state_ff == adc_pins_pkg::SP_WRITE) && last_bit
                                             && (addr_ff == `REG_CFG);
  wire logic                  four_wire    = cfg_ff[`CFG_FOUR_WIRE];

  // Status word: buffer level, sync running, powered down
  logic [`FIFO_LVL_W-1:0] fifo_level;   // Words in buffer
  logic                   sync_run_ff;  // Sync output started
  logic                   pd_ff;        // Registered power-down
  wire logic [`SP_DATA_W-1:0] stat_word = {{`STAT_PAD_W{1'b0}}, fifo_level, sync_run_ff, pd_ff};
  wire logic [`SP_DATA_W-1:0] rd_word   = (cmd_addr == `REG_CFG)  ? cfg_ff :
                                          (cmd_addr == `REG_STAT) ? stat_word : '0;

  // Sequencer next state; dropping select aborts any frame
  always_comb begin
    nxt_state = state_ff;
    if (sel_n) begin
      nxt_state = adc_pins_pkg::SP_IDLE;
    end else begin
      case (state_ff)
        adc_pins_pkg::SP_IDLE: begin
          if (sel_fall) begin
            nxt_state = adc_pins_pkg::SP_CMD;
          end
        end
        adc_pins_pkg::SP_CMD: begin
          if (last_cmd_bit) begin
            nxt_state = cmd_read ? adc_pins_pkg::SP_READ : adc_pins_pkg::SP_WRITE;
          end
        end
        adc_pins_pkg::SP_WRITE: begin
          if (last_bit) begin
            nxt_state = adc_pins_pkg::SP_IDLE;
          end
        end
        adc_pins_pkg::SP_READ: begin
          nxt_state = adc_pins_pkg::SP_READ;
        end
        default: begin
          nxt_state = adc_pins_pkg::SP_IDLE;
        end
      endcase
    end
  end

  // Frame shifting; a read bit moves on only after the host rise that took it,
  // so the first bit survives the fall that follows the last command bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff    <= adc_pins_pkg::SP_IDLE;
      bit_cnt_ff  <= '0;
      in_shift_ff <= '0;
      rd_shift_ff <= '0;
      addr_ff     <= '0;
    end else begin
      state_ff    <= nxt_state;
      bit_cnt_ff  <= (state_ff == adc_pins_pkg::SP_IDLE) ? '0 :
                     (sclk_rise ? `SP_CNT_W'(bit_cnt_ff + 1'b1) : bit_cnt_ff);
      in_shift_ff <= sclk_rise ? {in_shift_ff[`SP_FRAME_W-2:0], din} : in_shift_ff;
      if ((state_ff == adc_pins_pkg::SP_CMD) && last_cmd_bit) begin
        addr_ff     <= cmd_addr;
        rd_shift_ff <= rd_word;
      end else if ((state_ff == adc_pins_pkg::SP_READ) && sclk_rise) begin
        rd_shift_ff <= {rd_shift_ff[`SP_DATA_W-2:0], 1'b0};
      end
    end
  end

  // Configuration register; the reset pin clears it with no clock edge
  always_ff @(posedge clk_sys or negedge serial_port_reset_n) begin
    if (!serial_port_reset_n) begin
      cfg_ff <= `CFG_DEFAULT;
    end else if (rst) begin
      cfg_ff <= `CFG_DEFAULT;
    end else if (cfg_write) begin
      cfg_ff <= wr_word;
    end
  end

  // Serial pin drivers; three-wire turns the data pin round, four-wire does not
  wire logic reading     = (state_ff == adc_pins_pkg::SP_READ) && !sel_n;
  logic      dio_out_ff;   // Two-way pin level
  logic      dio_oe_ff;    // Two-way pin enable
  logic      sdo_out_ff;   // Separate output level
  logic      sdo_oe_ff;    // Separate output enable

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dio_out_ff <= 1'b0;
      dio_oe_ff  <= 1'b0;
      sdo_out_ff <= 1'b0;
      sdo_oe_ff  <= 1'b0;
    end else begin
      dio_out_ff <= rd_shift_ff[`SP_DATA_W-1];
      dio_oe_ff  <= reading && !four_wire;
      sdo_out_ff <= four_wire && rd_shift_ff[`SP_DATA_W-1];
      sdo_oe_ff  <= reading && four_wire;
    end
  end

  // Power-down from the pin or the register bit
  wire logic nxt_pd = !enable_s || cfg_ff[`CFG_PWR_DOWN];

  // Sample buffer; a stalled drain pushes back on the core
  logic [`FIFO_W-1:0] fifo_word;   // Oldest sample pair
  logic               fifo_valid;  // Buffer holds a pair
  logic               fifo_ready;  // Buffer has room
  logic [`PH_W-1:0]   phase_ff;    // Output clock divider phase
  wire logic [`PH_W-1:0] nxt_phase = sync_rise ? `PH_START : `PH_W'(phase_ff + 1'b1);
  wire logic             win_start = !nxt_phase[0] && !pd_ff;   // New data window begins
  wire logic             take      = win_start && fifo_valid;

  sample_fifo #(
    .WIDTH (`FIFO_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clear     (sync_rise),
    .in_valid  (core_valid),
    .in_ready  (fifo_ready),
    .in_data   ({core_over_b, core_over_a, core_sample_b, core_sample_a}),
    .out_valid (fifo_valid),
    .out_ready (take),
    .out_data  (fifo_word),
    .level     (fifo_level)
  );

  // Clock level per phase: an edge sits mid-window, the polarity picks which
  function automatic logic fwd_level(input logic [`PH_W-1:0] ph, input logic fall_mid);
    fwd_level = (ph[0] ^ ph[1]) ^ fall_mid;
  endfunction

  // Sync marker: one window in every sixteen once started
  logic [`SYNC_CNT_W-1:0] sync_cnt_ff;   // Window counter
  wire logic mark      = sync_run_ff && (sync_cnt_ff == `SYNC_MARK);
  wire logic sync_next = mark && !cfg_ff[`CFG_SYNC_DIS];

  // Output registers; everything on the buses leaves a flop
  logic [`SAMPLE_W-1:0] bus_a_ff;      // Channel A bus
  logic [`SAMPLE_W-1:0] bus_b_ff;      // Channel B bus
  logic                 clk_a_ff;      // Channel A clock
  logic                 clk_b_ff;      // Channel B clock
  logic                 sync_out_ff;   // Sync output
  logic                 ovr_a_ff;      // Channel A overrange
  logic                 ovr_b_ff;      // Channel B overrange
  logic                 core_rst_ff;   // Core restart pulse

  // Divider, sync counter and power state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_ff    <= `PH_START;
      sync_run_ff <= 1'b0;
      sync_cnt_ff <= `SYNC_MARK;
      pd_ff       <= 1'b1;
      core_rst_ff <= 1'b0;
    end else begin
      phase_ff    <= nxt_phase;
      pd_ff       <= nxt_pd;
      core_rst_ff <= sync_rise;
      if (sync_rise) begin
        sync_run_ff <= 1'b1;
        sync_cnt_ff <= `SYNC_MARK;
      end else if (win_start) begin
        sync_cnt_ff <= `SYNC_CNT_W'(sync_cnt_ff + 1'b1);
      end
    end
  end

  // Bus drivers; in power-down every output rests low
  always_ff @(posedge clk_sys) begin
    if (rst || pd_ff) begin
      bus_a_ff    <= '0;
      bus_b_ff    <= '0;
      clk_a_ff    <= 1'b0;
      clk_b_ff    <= 1'b0;
      sync_out_ff <= 1'b0;
      ovr_a_ff    <= 1'b0;
      ovr_b_ff    <= 1'b0;
    end else begin
      clk_a_ff <= fwd_level(nxt_phase, cfg_ff[`CFG_A_FALL_MID]);
      // Shared-clock option parks the B clock; B then follows A timing
      clk_b_ff <= cfg_ff[`CFG_B_ON_A_CLK] ? 1'b0 :
                  fwd_level(nxt_phase, cfg_ff[`CFG_B_FALL_MID]);
      if (win_start) begin
        if (take) begin
          bus_a_ff <= fifo_word[`SAMPLE_W-1:0];
          bus_b_ff <= fifo_word[2*`SAMPLE_W-1:`SAMPLE_W];
        end
        sync_out_ff <= sync_next;
        ovr_a_ff    <= cfg_ff[`CFG_OVRA_SYNC] ? sync_next :
                       (take && fifo_word[`WORD_OVR_A]);
        ovr_b_ff    <= cfg_ff[`CFG_OVRB_SYNC] ? sync_next :
                       (take && fifo_word[`WORD_OVR_B]);
      end
    end
  end

  assign serial_dio_out     = dio_out_ff;
  assign serial_dio_oe      = dio_oe_ff;
  assign serial_data_out    = sdo_out_ff;
  assign serial_data_out_oe = sdo_oe_ff;
  assign core_ready         = fifo_ready;
  assign chan_a_sample_bus  = bus_a_ff;
  assign chan_b_sample_bus  = bus_b_ff;
  assign chan_a_fwd_clock   = clk_a_ff;
  assign chan_b_fwd_clock   = clk_b_ff;
  assign sync_out_pair      = sync_out_ff;
  assign chan_a_overrange   = ovr_a_ff;
  assign chan_b_overrange   = ovr_b_ff;
  assign core_sync_reset    = core_rst_ff;
  assign powered_down       = pd_ff;

endmodule
`default_nettype wire

// File: verif/adc_pin_interface_asserts.sv
// Port assertions for the converter pin interface
`timescale 1ns/10ps
`default_nettype none
`include "adc_pins_defines.svh"
module adc_pin_checker (
  input wire logic                 clk_sys,            // System clock
  input wire logic                 rst,                // Sync reset
  input wire logic                 serial_select_n,    // Frame select
  input wire logic                 serial_dio_oe,      // Two-way pin drive
  input wire logic                 serial_data_out_oe, // Output pin drive
  input wire logic                 sync_in_pair,       // Sync input
  input wire logic                 core_ready,         // Buffer room
  input wire logic [`SAMPLE_W-1:0] chan_a_sample_bus,  // Bus A
  input wire logic [`SAMPLE_W-1:0] chan_b_sample_bus,  // Bus B
  input wire logic                 chan_a_overrange,   // Overrange A
  input wire logic                 chan_b_overrange,   // Overrange B
  input wire logic                 sync_out_pair,      // Sync marker
  input wire logic                 core_sync_reset,    // Restart pulse
  input wire logic                 powered_down        // Power state
);
  default clocking cb @(posedge clk_sys); endclocking
  // A restart lasts exactly one cycle
  sequence s_pulse;
    core_sync_reset ##1 !core_sync_reset;
  endsequence
  // Select idle long enough to release
  sequence s_sel_idle;
    serial_select_n [*6];
  endsequence
  // Reset is the cause, so no disable
  property p_reset_quiet;
    rst |=> powered_down && !core_ready && !core_sync_reset && !sync_out_pair
      && !serial_dio_oe && !serial_data_out_oe && chan_a_sample_bus == 12'h000;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("active in reset");
  property p_one_driver;
    disable iff (rst) !(serial_dio_oe && serial_data_out_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both data pins driven");
  property p_drive_in_frame;
    disable iff (rst) $rose(serial_dio_oe) || $rose(serial_data_out_oe) |-> !serial_select_n;
  endproperty
  a_drive_in_frame: assert property (p_drive_in_frame) else $error("drive outside frame");
  property p_oe_idle;
    disable iff (rst) s_sel_idle |-> !serial_dio_oe && !serial_data_out_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("pin driven while idle");
  property p_sync_react;
    disable iff (rst) $rose(sync_in_pair) && !powered_down |-> ##[1:8] s_pulse;
  endproperty
  a_sync_react: assert property (p_sync_react) else $error("sync edge not acted on");
  property p_sync_cause;
    disable iff (rst) core_sync_reset |-> $past(sync_in_pair);
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("restart without sync");
  property p_pulse_once;
    disable iff (rst) core_sync_reset |=> !core_sync_reset;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("restart too long");
  property p_pd_quiet;
    disable iff (rst) powered_down && $past(powered_down) |-> chan_a_sample_bus == 12'h000
      && chan_b_sample_bus == 12'h000 && !chan_a_overrange && !chan_b_overrange;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("bus active in power down");
  // A word stands a whole two-cycle window
  property p_bus_window;
    disable iff (rst) !powered_down && $changed(chan_a_sample_bus)
      |=> $stable(chan_a_sample_bus) || powered_down;
  endproperty
  a_bus_window: assert property (p_bus_window) else $error("bus word too short");
endmodule
bind adc_pin_interface adc_pin_checker chk_u (
  .clk_sys, .rst, .serial_select_n, .serial_dio_oe, .serial_data_out_oe, .sync_in_pair,
  .core_ready, .chan_a_sample_bus, .chan_b_sample_bus, .chan_a_overrange,
  .chan_b_overrange, .sync_out_pair, .core_sync_reset, .powered_down
);
`default_nettype wire

// File: verif/adc_far_side_model.sv
// Host serial controller and bus capture models
`timescale 1ns/10ps
`default_nettype none
module serial_host (
  input  wire logic clk_sys,            // Paces the host
  output logic      serial_clock,       // Serial clock
  output logic      serial_select_n,    // Frame select
  output logic      serial_dio_in,      // Level on the two-way pin
  input  wire logic serial_dio_out,     // Device level on the pin
  input  wire logic serial_dio_oe,      // Device drives the pin
  input  wire logic serial_data_out,    // Separate output pin
  input  wire logic serial_data_out_oe  // Separate output drive
);
  localparam int HALF = 6;  // Cycles per level, two needed
  logic host_en = 1'b0;     // Host drives the two-way pin
  logic host_bit = 1'b0;    // Host level
  // Pull-down wins when nobody drives
  assign serial_dio_in = serial_dio_oe ? serial_dio_out : (host_en & host_bit);
  initial begin
    serial_clock = 1'b0;
    serial_select_n = 1'b1;
  end
  // One frame, MSB first; read bits taken before each rise
  task automatic frame(input logic [31:0] word, input logic four, output logic [23:0] rd);
    int i;
    rd = 24'h000000;
    @(negedge clk_sys);
    serial_select_n = 1'b0;
    for (i = 31; i >= 0; i--) begin
      host_en = !word[31] || i > 23;  // Let go of the line for read data
      host_bit = word[i];
      repeat (HALF) @(negedge clk_sys);
      if (i < 24) rd[i] = four ? (serial_data_out_oe & serial_data_out) : serial_dio_in;
      serial_clock = 1'b1;
      repeat (HALF) @(negedge clk_sys);
      serial_clock = 1'b0;
    end
    host_en = 1'b0;
    repeat (HALF) @(negedge clk_sys);
    serial_select_n = 1'b1;
    repeat (HALF) @(negedge clk_sys);  // Gap before the next frame
  endtask
endmodule
module sample_capture (
  input wire logic        chan_a_fwd_clock,  // Capture clock for both buses
  input wire logic [11:0] chan_a_sample_bus, // Bus A
  input wire logic [11:0] chan_b_sample_bus, // Bus B
  input wire logic        chan_a_overrange,  // Overrange A
  input wire logic        chan_b_overrange   // Overrange B
);
  logic [25:0] words [$];           // New words, oldest first
  logic [23:0] last = 24'h000000;   // Previous pair; a held bus is not new
  logic [23:0] pair;                // Both buses
  assign pair = {chan_b_sample_bus, chan_a_sample_bus};
  // Both edges of the A clock capture both buses
  always @(chan_a_fwd_clock) begin
    if (pair !== last && pair !== 24'h000000) begin
      words.push_back({chan_b_overrange, chan_a_overrange, pair});
    end
    last = pair;
  end
endmodule
`default_nettype wire

// File: verif/adc_pin_interface_test.sv
// Self-checking bench for the converter pin interface
`timescale 1ns/10ps
`default_nettype none
module adc_pin_interface_test;
  logic        clk_sys = 1'b0, rst = 1'b1, serial_port_reset_n = 1'b1, chip_enable = 1'b1;
  logic        sync_in_pair = 1'b0, core_valid = 1'b0, core_over_a = 1'b0, core_over_b = 1'b0;
  logic [11:0] core_sample_a = 12'h000, core_sample_b = 12'h000;
  logic [11:0] chan_a_sample_bus, chan_b_sample_bus;
  logic        serial_clock, serial_select_n, serial_dio_in, serial_dio_out, serial_dio_oe;
  logic        serial_data_out, serial_data_out_oe, core_ready, chan_a_fwd_clock;
  logic        chan_b_fwd_clock, sync_out_pair, chan_a_overrange, chan_b_overrange;
  logic        core_sync_reset, powered_down;
  logic [23:0] rdv;  // Last read data
  logic [23:0] modes [4] = '{24'h000000, 24'h000066, 24'h00002A, 24'h000030};
  int          bad_count = 0, total_checks = 0;
  always #25 clk_sys = ~clk_sys;
  adc_pin_interface dut_u (
    .clk_sys, .rst, .serial_port_reset_n, .chip_enable, .serial_clock, .serial_select_n,
    .serial_dio_in, .serial_dio_out, .serial_dio_oe, .serial_data_out, .serial_data_out_oe,
    .sync_in_pair, .core_sample_a, .core_sample_b, .core_over_a, .core_over_b, .core_valid,
    .core_ready, .chan_a_sample_bus, .chan_b_sample_bus, .chan_a_fwd_clock, .chan_b_fwd_clock,
    .sync_out_pair, .chan_a_overrange, .chan_b_overrange, .core_sync_reset, .powered_down
  );
  serial_host host_u (
    .clk_sys, .serial_clock, .serial_select_n, .serial_dio_in, .serial_dio_out,
    .serial_dio_oe, .serial_data_out, .serial_data_out_oe
  );
  sample_capture cap_u (
    .chan_a_fwd_clock, .chan_a_sample_bus, .chan_b_sample_bus, .chan_a_overrange,
    .chan_b_overrange
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    logic [23:0] x;
    host_u.frame({1'b0, a, d}, 1'b0, x);
  endtask
  task automatic rd(input logic [6:0] a, input logic four);
    host_u.frame({1'b1, a, 24'h000000}, four, rdv);
  endtask
  // Chip enable, register power down, four-wire read, then serial reset
  task automatic t_power();
    chip_enable = 1'b0;
    cycles(6);
    check(32'(powered_down), 32'h1);
    chip_enable = 1'b1;
    cycles(6);
    check(32'(powered_down), 32'h0);
    wr(7'h00, 24'h010001);
    cycles(6);
    check(32'(powered_down), 32'h1);
    rd(7'h00, 1'b1);
    check({8'h00, rdv}, 32'h00010001);
    serial_port_reset_n = 1'b0;
    cycles(3);
    serial_port_reset_n = 1'b1;
    cycles(6);
    check(32'(powered_down), 32'h0);
  endtask
  // Three-wire readback: reset left three-wire
  task automatic t_regs();
    wr(7'h00, 24'h000046);
    rd(7'h00, 1'b0);
    check({8'h00, rdv}, 32'h00000046);
    wr(7'h05, 24'hFFFFFF);
    rd(7'h00, 1'b0);
    check({8'h00, rdv}, 32'h00000046);
    rd(7'h05, 1'b0);
    check({8'h00, rdv}, 32'h00000000);
  endtask
  // Fill while stalled, then drain to the buses
  task automatic t_fill();
    int i, n;
    wr(7'h00, 24'h000001);
    cap_u.words.delete();
    n = 0;
    for (i = 0; i < 20; i++) begin
      core_sample_a = 12'hA00 + 12'(n);
      core_sample_b = 12'h500 + 12'(n);
      core_over_a = n[0];
      core_over_b = n[1];
      core_valid = 1'b1;
      if (core_ready) n++;
      @(negedge clk_sys);
    end
    core_valid = 1'b0;
    check(32'(n), 32'd16);
    rd(7'h01, 1'b0);
    check({8'h00, rdv & 24'hFFFFFD}, 32'h00000041);
    wr(7'h00, 24'h000000);
    cycles(60);
    check(32'(cap_u.words.size()), 32'd16);
    for (i = 0; i < 16 && i < cap_u.words.size(); i++) begin
      check({6'h00, cap_u.words[i]}, {6'h00, i[1], i[0], 12'h500 + 12'(i), 12'hA00 + 12'(i)});
    end
    rd(7'h01, 1'b0);
    check({8'h00, rdv & 24'hFFFFFD}, 32'h00000000);
  endtask
  // Sync restart, marker, clock phase, overrange reuse
  task automatic t_sync(input logic [23:0] cfg);
    int i;
    wr(7'h00, cfg);
    sync_in_pair = 1'b1;
    cycles(12);
    sync_in_pair = 1'b0;
    for (i = 0; i < 80 && sync_out_pair !== 1'b1; i++) begin
      @(negedge clk_sys);
    end
    check(32'(i < 80), 32'(!cfg[4]));
    if (i < 80) begin
      check(32'(chan_a_fwd_clock), 32'(!cfg[1]));
      check(32'(chan_b_fwd_clock), 32'(!cfg[2] && !cfg[3]));
      check(32'(chan_a_overrange), 32'(cfg[5]));
      check(32'(chan_b_overrange), 32'(cfg[6]));
    end
  endtask
  initial begin
    cycles(5);
    check(32'(powered_down), 32'h1);
    rst = 1'b0;
    cycles(8);
    check(32'(powered_down), 32'h0);
    t_power();
    t_regs();
    t_fill();
    foreach (modes[m]) t_sync(modes[m]);
    end_sim();
  end
  // Watchdog, well past the run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
